// ---- dcaip_pkg.sv ----
// package: constants, types and helpers for the command/address input port
package dcaip_pkg;

   // ------------------------------------------------------------------
   // widths and organisation
   // ------------------------------------------------------------------
   localparam int         ADDR_W         = 14;
   localparam int         BANK_W         = 2;
   localparam int         NBANK          = 4;
   localparam int         COL_W          = 11;
   localparam int         DQ_W           = 16;
   localparam int         PAGE_W         = 12;
   localparam logic [1:0] ORG_X4         = 2'h0;
   localparam logic [1:0] ORG_X8         = 2'h1;
   localparam logic [1:0] ORG_X16        = 2'h2;
   localparam int         COL_BITS_X4    = 11;
   localparam int         COL_BITS_STD   = 10;
   localparam int         IO_X4          = 4;
   localparam int         IO_X8          = 8;
   localparam int         IO_X16         = 16;
   localparam int         BITS_PER_BYTE  = 8;
   localparam int         ROW_TOP_X16    = 12;
   localparam int         AP_BIT         = 10;
   localparam int         COL_HI_BIT     = 11;

   // ------------------------------------------------------------------
   // mode register selection and termination field
   // ------------------------------------------------------------------
   localparam logic [1:0] MR_BANK        = 2'h0;
   localparam logic [1:0] EXT_MR_BANK    = 2'h1;
   localparam int         RTT_BIT_LO     = 2;
   localparam int         RTT_BIT_HI     = 6;

   // ------------------------------------------------------------------
   // reset values and the all-banks precharge mask
   // ------------------------------------------------------------------
   localparam logic [1:0] ORG_RST        = ORG_X4;
   localparam logic       ODT_OFF_RST    = 1'b1;
   localparam logic [3:0] OPEN_RST       = 4'h0;
   localparam logic [3:0] BANKS_ALL      = 4'hF;

   typedef enum logic [3:0] {
      CMD_DESEL, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR,
      CMD_PRE, CMD_REF, CMD_MRS, CMD_RSVD
   } dcaip_cmd_t;

   typedef enum logic [2:0] {
      PWR_AWAKE, PWR_ACT_PD, PWR_PRE_PD, PWR_SELF_REF, PWR_SR_EXIT
   } dcaip_pwr_t;

   typedef struct packed {
      logic              cs_n;
      logic              ras_n;
      logic              cas_n;
      logic              we_n;
      logic [BANK_W-1:0] bank;
      logic [ADDR_W-1:0] addr;
   } dcaip_pins_t;

   localparam dcaip_pins_t PINS_DESEL = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                                          we_n: 1'b1, bank: 2'h0, addr: 14'h0};

   typedef struct packed {
      dcaip_cmd_t        cmd;
      logic [BANK_W-1:0] bank;
      logic [ADDR_W-1:0] row;
      logic [COL_W-1:0]  col;
      logic              auto_pre;
      logic              pre_all;
   } dcaip_req_t;

   typedef struct packed {
      logic int_clk;
      logic out_drv;
      logic clk_rx;
      logic cke_rx;
      logic term_rx;
      logic cmd_rx;
   } dcaip_buf_t;

   function automatic int col_bits(input logic [1:0] org);
      return (org == ORG_X4) ? COL_BITS_X4 : COL_BITS_STD;
   endfunction

   function automatic int io_width(input logic [1:0] org);
      return (org == ORG_X16) ? IO_X16 : ((org == ORG_X8) ? IO_X8 : IO_X4);
   endfunction

   function automatic logic [PAGE_W-1:0] page_bytes(input logic [1:0] org);
      int b;
      b = (1 << col_bits(org)) * io_width(org) / BITS_PER_BYTE;
      return b[PAGE_W-1:0];
   endfunction

endpackage

// ---- dcaip_cmd_dec.sv ----
// command decoder and organisation-dependent address split
`timescale 1ns/1ps
module dcaip_cmd_dec (
   // captured pins
   input  dcaip_pkg::dcaip_pins_t pins,
   input  wire logic [1:0]        org,
   // decoded request
   output dcaip_pkg::dcaip_req_t  req
);

   // ------------------------------------------------------------------
   // command code
   // ------------------------------------------------------------------
   function automatic dcaip_pkg::dcaip_cmd_t code_of(input logic [2:0] rcw);
      case (rcw)
         3'h7:    return dcaip_pkg::CMD_NOP;
         3'h3:    return dcaip_pkg::CMD_ACT;
         3'h5:    return dcaip_pkg::CMD_RD;
         3'h4:    return dcaip_pkg::CMD_WR;
         3'h2:    return dcaip_pkg::CMD_PRE;
         3'h1:    return dcaip_pkg::CMD_REF;
         3'h0:    return dcaip_pkg::CMD_MRS;
         default: return dcaip_pkg::CMD_RSVD;
      endcase
   endfunction

   wire logic [2:0]             rcw     = {pins.ras_n, pins.cas_n, pins.we_n};
   wire dcaip_pkg::dcaip_cmd_t  cmd     = pins.cs_n ? dcaip_pkg::CMD_DESEL
                                                    : code_of(rcw);
   wire logic                   is_x16  = (org == dcaip_pkg::ORG_X16);
   wire logic                   is_x4   = (org == dcaip_pkg::ORG_X4);
   wire logic                   is_rdwr = (cmd == dcaip_pkg::CMD_RD) || (cmd == dcaip_pkg::CMD_WR);
   wire logic                   ap      = pins.addr[dcaip_pkg::AP_BIT];

   // ------------------------------------------------------------------
   // address map
   // ------------------------------------------------------------------
   assign req.cmd      = cmd;
   assign req.bank     = pins.bank;
   assign req.row      = is_x16 ? {1'b0, pins.addr[dcaip_pkg::ROW_TOP_X16:0]}
                                : pins.addr;
   assign req.col      = is_x4 ? {pins.addr[dcaip_pkg::COL_HI_BIT], pins.addr[9:0]}
                               : {1'b0, pins.addr[9:0]};
   assign req.auto_pre = is_rdwr && ap;
   assign req.pre_all  = (cmd == dcaip_pkg::CMD_PRE) && ap;

endmodule

// ---- dcaip_pwr_fsm.sv ----
// clock-enable power state machine and receiver/driver enables
`timescale 1ns/1ps
module dcaip_pwr_fsm (
   // clock and reset
   input  wire logic            ref_clk,
   input  wire logic            resetn,
   // clock enable and current command
   input  wire logic            cke_in,
   input  dcaip_pkg::dcaip_cmd_t cmd,
   input  wire logic            any_open,
   // state
   output dcaip_pkg::dcaip_pwr_t state_r,
   output dcaip_pkg::dcaip_buf_t buf_r,
   output logic                 cke_r,
   output logic                 accept
);

   dcaip_pkg::dcaip_pwr_t state_nxt;
   dcaip_pkg::dcaip_buf_t buf_nxt;

   wire logic awake    = (state_r == dcaip_pkg::PWR_AWAKE);
   wire logic cke_fall = awake && cke_r && !cke_in;

   // commands only while clock enable stays high across the edge
   assign accept = awake && cke_r && cke_in;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         dcaip_pkg::PWR_AWAKE: begin
            if (cke_fall) begin
               if (cmd == dcaip_pkg::CMD_REF) begin
                  state_nxt = dcaip_pkg::PWR_SELF_REF;
               end else if (any_open) begin
                  state_nxt = dcaip_pkg::PWR_ACT_PD;
               end else begin
                  state_nxt = dcaip_pkg::PWR_PRE_PD;
               end
            end
         end
         dcaip_pkg::PWR_ACT_PD,
         dcaip_pkg::PWR_PRE_PD: begin
            if (cke_in) begin
               state_nxt = dcaip_pkg::PWR_AWAKE;
            end
         end
         dcaip_pkg::PWR_SELF_REF: begin
            if (cke_in) begin
               state_nxt = dcaip_pkg::PWR_SR_EXIT;
            end
         end
         dcaip_pkg::PWR_SR_EXIT: begin
            state_nxt = dcaip_pkg::PWR_AWAKE;
         end
         default: state_nxt = dcaip_pkg::PWR_PRE_PD;
      endcase
   end

   // enables follow the next state so they line up with state_r
   always_comb begin
      buf_nxt = '0;
      case (state_nxt)
         dcaip_pkg::PWR_AWAKE,
         dcaip_pkg::PWR_SR_EXIT: buf_nxt = '1;
         dcaip_pkg::PWR_ACT_PD,
         dcaip_pkg::PWR_PRE_PD: begin
            buf_nxt.clk_rx  = 1'b1;
            buf_nxt.term_rx = 1'b1;
            buf_nxt.cke_rx  = 1'b1;
         end
         dcaip_pkg::PWR_SELF_REF: buf_nxt.cke_rx = 1'b1;
         default: buf_nxt = '0;
      endcase
   end

   // power-up: clock enable assumed low, all banks idle
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= dcaip_pkg::PWR_PRE_PD;
         buf_r   <= '{clk_rx: 1'b1, term_rx: 1'b1, cke_rx: 1'b1, default: 1'b0};
         cke_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         buf_r   <= buf_nxt;
         cke_r   <= cke_in;
      end
   end

endmodule

// ---- dcaip_port.sv ----
// command/address input port of a four-bank double-data-rate-two memory
`timescale 1ns/1ps
module dcaip_port (
   // clock and reset
   input  wire logic                            ref_clk,
   input  wire logic                            resetn,
   // organisation strap, caught after reset
   input  wire logic [1:0]                      org_sel,
   // command and address pins
   input  wire logic                            cke_in,
   input  wire logic                            cs_n_in,
   input  wire logic                            ras_n_in,
   input  wire logic                            cas_n_in,
   input  wire logic                            we_n_in,
   input  wire logic [dcaip_pkg::BANK_W-1:0]    bank_in,
   input  wire logic [dcaip_pkg::ADDR_W-1:0]    addr_in,
   input  wire logic                            term_ctrl_in,
   // read data from the core, two beats per clock
   input  wire logic                            rd_valid_in,
   input  wire logic [dcaip_pkg::DQ_W-1:0]      rd_rise_in,
   input  wire logic [dcaip_pkg::DQ_W-1:0]      rd_fall_in,
   // decoded request to the core
   output dcaip_pkg::dcaip_req_t                req_r,
   output logic                                 req_valid_r,
   output logic                                 ext_config_load_r,
   output logic [dcaip_pkg::NBANK-1:0]          open_banks_r,
   // power state and enables
   output dcaip_pkg::dcaip_pwr_t                pwr_state_r,
   output dcaip_pkg::dcaip_buf_t                buf_en_r,
   // termination
   output logic                                 term_en_r,
   output logic                                 term_read_strobe_pin_r,
   output logic                                 term_upper_r,
   // organisation facts
   output logic [1:0]                           org_r,
   output logic [dcaip_pkg::PAGE_W-1:0]         page_bytes_r,
   // read data drivers
   output logic [dcaip_pkg::DQ_W-1:0]           dq_rise_r,
   output logic [dcaip_pkg::DQ_W-1:0]           dq_fall_r,
   output logic                                 dq_oe_n_r
);

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   dcaip_pkg::dcaip_req_t          req;
   dcaip_pkg::dcaip_pins_t         pins_raw;
   dcaip_pkg::dcaip_pins_t         pins_cur;
   logic                           accept;
   logic                           cke_r;
   logic                           strap_done_r;
   logic                           odt_off_r;
   logic                           odt_off_nxt;
   logic [dcaip_pkg::NBANK-1:0]    open_nxt;
   logic [dcaip_pkg::NBANK-1:0]    bank_hot;
   logic [dcaip_pkg::NBANK-1:0]    act_set;
   logic [dcaip_pkg::NBANK-1:0]    pre_clr;
   logic                           take;
   logic                           ext_load;
   logic                           drive;
   logic                           term_nxt;

   // ------------------------------------------------------------------
   // pin capture
   // ------------------------------------------------------------------
   assign pins_raw = '{cs_n: cs_n_in, ras_n: ras_n_in, cas_n: cas_n_in,
                       we_n: we_n_in, bank: bank_in, addr: addr_in};

   // a switched-off receiver looks like a deselected bus
   assign pins_cur = buf_en_r.cmd_rx ? pins_raw : dcaip_pkg::PINS_DESEL;

   dcaip_cmd_dec u_dec (
      .pins (pins_cur),
      .org  (org_r),
      .req  (req)
   );

   dcaip_pwr_fsm u_pwr (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .cke_in   (cke_in),
      .cmd      (req.cmd),
      .any_open (|open_banks_r),
      .state_r  (pwr_state_r),
      .buf_r    (buf_en_r),
      .cke_r    (cke_r),
      .accept   (accept)
   );

   // ------------------------------------------------------------------
   // command acceptance and bank tracking
   // ------------------------------------------------------------------
   assign take     = accept && (req.cmd != dcaip_pkg::CMD_DESEL)
                            && (req.cmd != dcaip_pkg::CMD_NOP);
   assign bank_hot = dcaip_pkg::NBANK'(1) << req.bank;
   assign act_set  = (take && req.cmd == dcaip_pkg::CMD_ACT) ? bank_hot : '0;
   // auto-precharge closes the bank as the access is taken; core times it
   assign pre_clr  = (take && req.pre_all) ? dcaip_pkg::BANKS_ALL :
                     (take && req.cmd == dcaip_pkg::CMD_PRE) ? bank_hot :
                     (take && req.auto_pre) ? bank_hot : '0;
   assign open_nxt = (open_banks_r & ~pre_clr) | act_set;

   // ------------------------------------------------------------------
   // extended configuration and termination
   // ------------------------------------------------------------------
   assign ext_load    = take && (req.cmd == dcaip_pkg::CMD_MRS)
                             && (req.bank == dcaip_pkg::EXT_MR_BANK);
   assign odt_off_nxt = ext_load ? !(pins_cur.addr[dcaip_pkg::RTT_BIT_LO] ||
                                     pins_cur.addr[dcaip_pkg::RTT_BIT_HI])
                                 : odt_off_r;
   assign term_nxt    = buf_en_r.term_rx && term_ctrl_in && !odt_off_r;

   // ------------------------------------------------------------------
   // read data path
   // ------------------------------------------------------------------
   // drivers only open while clock enable keeps them powered
   assign drive = buf_en_r.out_drv && rd_valid_in;

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         req_r             <= '0;
         req_valid_r       <= 1'b0;
         ext_config_load_r <= 1'b0;
         open_banks_r      <= dcaip_pkg::OPEN_RST;
      end else begin
         req_r             <= req;
         req_valid_r       <= take;
         ext_config_load_r <= ext_load;
         open_banks_r      <= open_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         odt_off_r    <= dcaip_pkg::ODT_OFF_RST;
         term_en_r    <= 1'b0;
         term_read_strobe_pin_r  <= 1'b0;
         term_upper_r <= 1'b0;
      end else begin
         odt_off_r    <= odt_off_nxt;
         term_en_r    <= term_nxt;
         term_read_strobe_pin_r  <= term_nxt && (org_r == dcaip_pkg::ORG_X8);
         term_upper_r <= term_nxt && (org_r == dcaip_pkg::ORG_X16);
      end
   end

   // strap is caught once, on the first edge after reset release
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         strap_done_r <= 1'b0;
         org_r        <= dcaip_pkg::ORG_RST;
         page_bytes_r <= '0;
      end else begin
         strap_done_r <= 1'b1;
         if (!strap_done_r) begin
            org_r <= org_sel;
         end
         page_bytes_r <= dcaip_pkg::page_bytes(org_r);
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         dq_rise_r <= '0;
         dq_fall_r <= '0;
         dq_oe_n_r <= 1'b1;
      end else begin
         dq_oe_n_r <= !drive;
         if (drive) begin
            dq_rise_r <= rd_rise_in;
            dq_fall_r <= rd_fall_in;
         end
      end
   end

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   a_row_map_x16: assert property (req_valid_r && org_r == dcaip_pkg::ORG_X16
      |-> req_r.row[dcaip_pkg::ADDR_W-1] == 1'b0)
      else $error("x16 row uses the top address bit");

   a_col_map_narrow: assert property (accept && !cs_n_in && org_r != dcaip_pkg::ORG_X4
      ##1 req_valid_r |-> req_r.col == {1'b0, $past(addr_in[9:0])})
      else $error("column split wrong for x8 or x16");

   a_page_size: assert property (strap_done_r && $stable(org_r)
      |=> page_bytes_r == ((org_r == dcaip_pkg::ORG_X16) ? 12'h800 : 12'h400))
      else $error("page size does not match organisation");

   a_bank_capture: assert property (req_valid_r
      |-> req_r.bank == $past(bank_in) && req_r.cmd != dcaip_pkg::CMD_DESEL)
      else $error("request not taken from the previous edge");

   a_read_two_beats: assert property (drive
      |=> !dq_oe_n_r && dq_rise_r == $past(rd_rise_in) && dq_fall_r == $past(rd_fall_in))
      else $error("read beats not driven on the next clock");

   a_sr_buffers: assert property (pwr_state_r == dcaip_pkg::PWR_SELF_REF
      |-> buf_en_r == dcaip_pkg::dcaip_buf_t'{cke_rx: 1'b1, default: 1'b0})
      else $error("receiver left on during self-refresh");

   a_pd_buffers: assert property (pwr_state_r inside {dcaip_pkg::PWR_ACT_PD,
                                                      dcaip_pkg::PWR_PRE_PD}
      |-> buf_en_r.clk_rx && buf_en_r.term_rx && buf_en_r.cke_rx
          && !buf_en_r.cmd_rx && !buf_en_r.out_drv && !buf_en_r.int_clk)
      else $error("power-down receiver set wrong");

   a_awake_enables: assert property (pwr_state_r == dcaip_pkg::PWR_AWAKE
      |-> buf_en_r.int_clk && buf_en_r.out_drv && buf_en_r.cmd_rx)
      else $error("clocks or drivers off while awake");

   a_pd_entry_kind: assert property (pwr_state_r == dcaip_pkg::PWR_AWAKE && cke_r && !cke_in
      && req.cmd != dcaip_pkg::CMD_REF
      |=> pwr_state_r == ($past(|open_banks_r) ? dcaip_pkg::PWR_ACT_PD
                                               : dcaip_pkg::PWR_PRE_PD))
      else $error("wrong power-down kind on entry");

   a_sr_exit_seq: assert property (pwr_state_r == dcaip_pkg::PWR_SELF_REF && cke_in
      |=> pwr_state_r == dcaip_pkg::PWR_SR_EXIT ##1 pwr_state_r == dcaip_pkg::PWR_AWAKE)
      else $error("self-refresh exit not completed in two clocks");

   a_desel_masked: assert property (cs_n_in |=> !req_valid_r)
      else $error("command taken with chip select high");

   a_act_decode: assert property (accept && !cs_n_in && !ras_n_in && cas_n_in && we_n_in
      |=> req_valid_r && req_r.cmd == dcaip_pkg::CMD_ACT
          && open_banks_r[$past(bank_in)])
      else $error("activate not decoded or bank not opened");

   a_term_on: assert property (buf_en_r.term_rx && term_ctrl_in && !odt_off_r
      |=> term_en_r)
      else $error("termination not enabled");

   a_term_ignored: assert property (odt_off_r |=> !term_en_r)
      else $error("termination input honoured while disabled");

   a_pre_all_banks: assert property (req_valid_r && req_r.pre_all
      |-> open_banks_r == '0)
      else $error("precharge-all left a bank open");

   a_ext_select: assert property (ext_config_load_r
      |-> req_r.cmd == dcaip_pkg::CMD_MRS && req_r.bank == dcaip_pkg::EXT_MR_BANK)
      else $error("extended load without its bank select");

   a_sr_entry: assert property (pwr_state_r == dcaip_pkg::PWR_AWAKE && cke_r && !cke_in
      && req.cmd == dcaip_pkg::CMD_REF |=> pwr_state_r == dcaip_pkg::PWR_SELF_REF)
      else $error("refresh with clock enable low missed self-refresh");

   a_pd_exit: assert property (pwr_state_r inside {dcaip_pkg::PWR_ACT_PD,
                                                   dcaip_pkg::PWR_PRE_PD}
      && cke_in |=> pwr_state_r == dcaip_pkg::PWR_AWAKE)
      else $error("power-down exit missed");

   a_asleep_masked: assert property (pwr_state_r != dcaip_pkg::PWR_AWAKE |=> !req_valid_r)
      else $error("command taken while asleep");

   a_drv_off: assert property (!buf_en_r.out_drv |=> dq_oe_n_r)
      else $error("read drivers on while powered down");

   a_ap_closes: assert property (req_valid_r && req_r.auto_pre
      |-> !open_banks_r[req_r.bank])
      else $error("auto-precharge left its bank open");

   a_col_map_x4: assert property (accept && !cs_n_in && org_r == dcaip_pkg::ORG_X4
      ##1 req_valid_r |-> req_r.col == {$past(addr_in[dcaip_pkg::COL_HI_BIT]),
                                        $past(addr_in[9:0])})
      else $error("column split wrong for x4");

   a_term_read_strobe_pin: assert property (term_read_strobe_pin_r
      == (term_en_r && org_r == dcaip_pkg::ORG_X8))
      else $error("read strobe termination wrong");

   a_term_upper: assert property (term_upper_r
      == (term_en_r && org_r == dcaip_pkg::ORG_X16))
      else $error("upper lane termination wrong");

   a_rsvd_decode: assert property (accept && !cs_n_in && ras_n_in && cas_n_in && !we_n_in
      |=> req_valid_r && req_r.cmd == dcaip_pkg::CMD_RSVD)
      else $error("reserved code not flagged");

   c_self_refresh: cover property (pwr_state_r == dcaip_pkg::PWR_SR_EXIT);
   c_active_pd:    cover property (pwr_state_r == dcaip_pkg::PWR_ACT_PD);
   c_pre_all:      cover property (req_valid_r && req_r.pre_all);
   c_ext_load:     cover property (ext_config_load_r ##1 !odt_off_r);
   c_rsvd:         cover property (req_valid_r && req_r.cmd == dcaip_pkg::CMD_RSVD);

endmodule

// ---- dcaip_ctrl_model.sv ----
// memory controller model driving the command, address and clock-enable pins
`timescale 1ns/1ps
module dcaip_ctrl_model (
   // clock
   input  wire logic              ref_clk,
   // pins toward the port
   output logic                   cke,
   output dcaip_pkg::dcaip_pins_t pins,
   output logic                   term
);
   initial begin
      cke  = 1'b0;
      pins = dcaip_pkg::PINS_DESEL;
      term = 1'b0;
   end
   // ------------------------------------------------------------------
   // one command per call, driven after a falling edge
   // ------------------------------------------------------------------
   // cke is set with each command slot and the bench also raises it between slots; reads here are sent with it high
   task automatic send(input logic [3:0] sel, input logic [1:0] ba, input logic [13:0] a,
                       input logic ck);
      @(negedge ref_clk);
      cke  = ck;
      pins = '{cs_n: sel[3], ras_n: sel[2], cas_n: sel[1], we_n: sel[0], bank: ba,
               addr: a};
      @(negedge ref_clk);
      // chip select goes high and the other lines show the inverse, so a stale copy is never mistaken for a hold
      pins = '{cs_n: 1'b1, ras_n: ~sel[2], cas_n: ~sel[1], we_n: ~sel[0], bank: ~ba,
               addr: ~a};
   endtask
endmodule

// ---- ddr2_cmd_addr_input_port_tb_top.sv ----
// self-checking bench for the command/address input port
`timescale 1ns/1ps
module ddr2_cmd_addr_input_port_tb_top;
   // ------------------------------------------------------------------
   // signals and instances
   // ------------------------------------------------------------------
   logic                   ref_clk = 1'b0;
   logic                   resetn = 1'b0;
   logic [1:0]             org_sel = 2'h1;
   logic                   rdv = 1'b0;
   int                     err_total = 0;
   int                     checks_done = 0;
   int                     cyc = 0;
   logic                   cke, term, rq_v, ecl, t_en, t_rq, t_up, oe_n;
   dcaip_pkg::dcaip_pins_t pins;
   dcaip_pkg::dcaip_req_t  req;
   dcaip_pkg::dcaip_pwr_t  pwr;
   dcaip_pkg::dcaip_buf_t  be;
   logic [3:0]             ob;
   logic [1:0]             org;
   logic [11:0]            pg;
   logic [15:0]            dr, df;

   dcaip_ctrl_model ctl (.ref_clk(ref_clk), .cke(cke), .pins(pins), .term(term));
   dcaip_port uut (.ref_clk(ref_clk), .resetn(resetn), .org_sel(org_sel), .cke_in(cke),
      .cs_n_in(pins.cs_n), .ras_n_in(pins.ras_n), .cas_n_in(pins.cas_n), .we_n_in(pins.we_n),
      .bank_in(pins.bank), .addr_in(pins.addr), .term_ctrl_in(term), .rd_valid_in(rdv),
      .rd_rise_in(16'hA5C3), .rd_fall_in(16'h5A3C), .req_r(req), .req_valid_r(rq_v),
      .ext_config_load_r(ecl), .open_banks_r(ob), .pwr_state_r(pwr), .buf_en_r(be),
      .term_en_r(t_en), .term_read_strobe_pin_r(t_rq), .term_upper_r(t_up), .org_r(org), .page_bytes_r(pg),
      .dq_rise_r(dr), .dq_fall_r(df), .dq_oe_n_r(oe_n));

   always #12.5 ref_clk = ~ref_clk;
   // whole run needs well under a thousand cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         print_verdict();
      end
   end
   // ------------------------------------------------------------------
   // compare, reset and verdict
   // ------------------------------------------------------------------
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task automatic do_reset(input logic [1:0] o);
      resetn = 1'b0;
      org_sel = o;
      ctl.cke = 1'b0;
      repeat (20) @(negedge ref_clk);
      resetn = 1'b1;
      repeat (2) @(negedge ref_clk);
      ctl.cke = 1'b1;
      repeat (3) @(negedge ref_clk);
   endtask
   task automatic print_verdict;
      if (err_total == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_cmd;
      ctl.send(4'b0011, 2'h1, 14'h0123, 1'b1);
      chk(16'(rq_v), 16'h1);
      chk(16'(req.cmd), 16'(dcaip_pkg::CMD_ACT));
      chk(16'(req.row), 16'h0123);
      chk(16'(ob), 16'h2);
      ctl.send(4'b1010, 2'h2, 14'h0400, 1'b1);
      chk(16'(rq_v), 16'h0);
      ctl.send(4'b0010, 2'h2, 14'h0400, 1'b1);
      chk(16'(req.pre_all), 16'h1);
      chk(16'(ob), 16'h0);
   endtask
   task automatic t_term;
      ctl.term = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk(16'(t_en), 16'h0);
      ctl.send(4'b0000, 2'h1, 14'h0004, 1'b1);
      chk(16'(ecl), 16'h1);
      @(negedge ref_clk);
      chk(16'(t_en), 16'h1);
      chk(16'(t_rq), 16'h1);
      chk(16'(t_up), 16'h0);
      ctl.term = 1'b0;
      rdv = 1'b1;
      @(negedge ref_clk);
      rdv = 1'b0;
      chk({oe_n, dr[14:0]}, 16'h25C3);
      chk(df, 16'h5A3C);
   endtask
   task automatic t_pd;
      ctl.send(4'b0011, 2'h0, 14'h0001, 1'b1);
      ctl.send(4'b0111, 2'h0, 14'h0000, 1'b0);
      chk({pwr, 7'h0, be}, {dcaip_pkg::PWR_ACT_PD, 13'h000E});
      rdv = 1'b1;
      ctl.send(4'b0011, 2'h2, 14'h0001, 1'b0);
      rdv = 1'b0;
      chk({oe_n, rq_v, ob}, 6'h21);
      ctl.cke = 1'b1;
      @(negedge ref_clk);
      chk({pwr, 7'h0, be}, {dcaip_pkg::PWR_AWAKE, 13'h003F});
      ctl.send(4'b0010, 2'h0, 14'h0400, 1'b1);
      ctl.send(4'b0111, 2'h0, 14'h0000, 1'b0);
      chk(16'(pwr), 16'(dcaip_pkg::PWR_PRE_PD));
      ctl.cke = 1'b1;
      repeat (2) @(negedge ref_clk);
      ctl.send(4'b0001, 2'h0, 14'h0000, 1'b0);
      chk({pwr, 7'h0, be}, {dcaip_pkg::PWR_SELF_REF, 13'h0004});
      ctl.cke = 1'b1;
      @(negedge ref_clk);
      chk(16'(pwr), 16'(dcaip_pkg::PWR_SR_EXIT));
      @(negedge ref_clk);
      chk(16'(pwr), 16'(dcaip_pkg::PWR_AWAKE));
   endtask
   task automatic t_x16;
      chk(16'(pg), 16'h0800);
      chk(16'(org), 16'h2);
      ctl.term = 1'b1;
      ctl.send(4'b0000, 2'h1, 14'h0040, 1'b1);
      @(negedge ref_clk);
      chk(16'(t_up), 16'h1);
      chk(16'(t_rq), 16'h0);
      ctl.send(4'b0011, 2'h3, 14'h3FFF, 1'b1);
      chk(16'(req.row), 16'h1FFF);
      ctl.send(4'b0101, 2'h3, 14'h0BFF, 1'b1);
      chk(16'(req.col), 16'h03FF);
   endtask
   task automatic t_x4;
      chk(16'(org), 16'h0);
      chk(16'(pg), 16'h0400);
      ctl.send(4'b0011, 2'h0, 14'h0000, 1'b1);
      ctl.send(4'b0011, 2'h1, 14'h0000, 1'b1);
      ctl.send(4'b0010, 2'h1, 14'h0000, 1'b1);
      chk(16'(ob), 16'h1);
      ctl.send(4'b0101, 2'h0, 14'h0FFF, 1'b1);
      chk(16'(req.col), 16'h07FF);
      chk(16'(ob), 16'h0);
      ctl.send(4'b0110, 2'h0, 14'h0000, 1'b1);
      chk(16'(req.cmd), 16'(dcaip_pkg::CMD_RSVD));
   endtask

   initial begin
      do_reset(2'h1);
      chk(16'(pg), 16'h0400);
      t_cmd();
      t_term();
      t_pd();
      do_reset(2'h2);
      t_x16();
      do_reset(2'h0);
      t_x4();
      print_verdict();
   end
endmodule
